// ---- amg_pkg.sv ----
package amg_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] AMG_OFS_OPCFG = 8'h01;
  localparam logic [7:0] AMG_OFS_PROT  = 8'h02;
  localparam logic [7:0] AMG_OFS_GAIN  = 8'h03;
  localparam logic [7:0] AMG_OFS_STATE = 8'h04;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] AMG_RST_OPCFG = 8'h00;
  localparam logic [7:0] AMG_RST_PROT  = 8'h10;
  localparam logic [7:0] AMG_RST_GAIN  = 8'hff;
  localparam logic [7:0] AMG_RST_STATE = 8'h55;
  localparam logic [7:0] AMG_RD_NONE   = 8'h00;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int AMG_BIT_SOFT_RESET = 7;
  localparam int AMG_BIT_MODULATION = 6;
  localparam int AMG_BIT_UPPER_PAIR = 5;
  localparam int AMG_BIT_LOWER_PAIR = 4;
  localparam int AMG_BIT_LINEOUT_1  = 3;
  localparam int AMG_BIT_LINEOUT_2  = 2;
  localparam int AMG_BIT_LINEOUT_3  = 1;
  localparam int AMG_BIT_LINEOUT_4  = 0;
  localparam int AMG_BIT_PULSE_INJ  = 6;
  localparam int AMG_LSB_THERMAL    = 4;
  localparam int AMG_LSB_OVERCUR    = 2;
  localparam int AMG_LSB_CH1        = 6;
  localparam int AMG_LSB_CH2        = 4;
  localparam int AMG_LSB_CH3        = 2;
  localparam int AMG_LSB_CH4        = 0;
  localparam int AMG_CHANNELS       = 4;

  // ****************************************************************
  // field codes
  // ****************************************************************
  localparam logic       AMG_MOD_TWO_LEVEL   = 1'b0;
  localparam logic       AMG_MOD_SINGLE_SIDE = 1'b1;
  localparam logic [1:0] AMG_REQ_PLAY        = 2'b00;
  localparam logic [1:0] AMG_REQ_HIZ         = 2'b01;
  localparam logic [1:0] AMG_REQ_MUTE        = 2'b10;
  localparam logic [1:0] AMG_REQ_LOAD_CHECK  = 2'b11;
  localparam logic [1:0] AMG_GAIN_10DB       = 2'b00;
  localparam logic [1:0] AMG_GAIN_28DB       = 2'b11;
  localparam logic [1:0] AMG_TW_140C         = 2'b00;
  localparam logic [1:0] AMG_TW_130C         = 2'b01;
  localparam logic [1:0] AMG_TW_120C         = 2'b10;
  localparam logic [1:0] AMG_TW_110C         = 2'b11;

  // ****************************************************************
  // serial interface
  // ****************************************************************
  localparam logic [6:0] AMG_DEV_ADDR  = 7'h2c; // arbitrary value
  localparam logic [2:0] AMG_BIT_LAST  = 3'h7;
  localparam logic [2:0] AMG_BIT_FIRST = 3'h0;

  typedef enum logic [3:0] {
    AMG_ST_IDLE,
    AMG_ST_ADDR,
    AMG_ST_ACK_ADDR,
    AMG_ST_SUB,
    AMG_ST_ACK_SUB,
    AMG_ST_WDATA,
    AMG_ST_ACK_WR,
    AMG_ST_RDATA,
    AMG_ST_RACK
  } amg_i2c_state_t;

endpackage

// ---- amg_edge.sv ----
`timescale 1ns/1ps
module amg_edge #(
  parameter logic IDLE_LEVEL = 1'b1
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  // sampled line
  input  wire logic d,
  output logic      rise,
  output logic      fall
);

  logic prev;

  // previous level of the line
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prev <= IDLE_LEVEL;
    end else begin
      prev <= d;
    end
  end

  // edge strobes
  assign rise = d & ~prev;
  assign fall = ~d & prev;

endmodule

// ---- amg_chan.sv ----
`timescale 1ns/1ps
module amg_chan (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // stored request for this channel
  input  wire logic [1:0] req_code,
  input  wire logic       req_written,
  // diagnostic control
  input  wire logic       auto_load_check_skip,
  input  wire logic       channel_fault,
  output logic            load_check_start
);
  import amg_pkg::*;

  logic [1:0] prev_code;
  logic       prev_fault;
  logic       leave_hiz;
  logic       fault_rise;
  logic       manual;

  // previous request and fault level
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prev_code  <= AMG_REQ_HIZ;
      prev_fault <= 1'b0;
    end else begin
      prev_code  <= req_code;
      prev_fault <= channel_fault;
    end
  end

  // automatic and requested diagnostic triggers
  assign leave_hiz  = (prev_code == AMG_REQ_HIZ) &&
                      (req_code != AMG_REQ_HIZ);
  assign fault_rise = channel_fault & ~prev_fault;
  assign manual     = req_written && (req_code == AMG_REQ_LOAD_CHECK);

  // one-cycle start strobe
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      load_check_start <= 1'b0;
    end else begin
      load_check_start <= manual ||
        (!auto_load_check_skip && (leave_hiz || fault_rise));
    end
  end

endmodule

// ---- amg_mode_gain_state_regs.sv ----
`timescale 1ns/1ps
// Summary of operation
// - writing one to bit seven soft-resets
// - bit six picks modulation scheme
// - bit five parallels channels three, four
// - bit four parallels channels one, two
// - bits three..zero select per-channel line-out
// - operating configuration resets to 0x00
// - bit six enables pulse injection
// - bits five..four set thermal warning
// - bits three..two select overcurrent level
// - protection configuration resets to 0x10
// - two-bit gain code per channel
// - gain register resets to 0xff
// - two-bit state request per channel
// - code eleven starts channel load check
// - state register resets to 0x55
// - subaddress advances after every data byte
// - automatic load check leaving hi-z, fault
module amg_mode_gain_state_regs (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // serial bus, open drain data
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // operating configuration
  output logic            modulation_select,
  output logic            parallel_bridge_upper_pair,
  output logic            parallel_bridge_lower_pair,
  output logic            first_channel_lineout_select,
  output logic            second_channel_lineout_select,
  output logic            third_channel_lineout_select,
  output logic            fourth_channel_lineout_select,
  output logic            soft_reset_pulse,
  // protection configuration
  output logic            pulse_injection_enable,
  output logic [1:0]      thermal_warning_threshold,
  output logic [1:0]      overcurrent_level_select,
  // per-channel gain and state
  output logic [1:0]      first_channel_gain_code,
  output logic [1:0]      second_channel_gain_code,
  output logic [1:0]      third_channel_gain_code,
  output logic [1:0]      fourth_channel_gain_code,
  output logic [1:0]      first_channel_state_request,
  output logic [1:0]      second_channel_state_request,
  output logic [1:0]      third_channel_state_request,
  output logic [1:0]      fourth_channel_state_request,
  // load check
  input  wire logic       auto_load_check_skip,
  input  wire logic [3:0] channel_fault,
  output logic [3:0]      load_check_start
);
  import amg_pkg::*;

  // ****************************************************************
  // signals
  // ****************************************************************
  amg_i2c_state_t state;
  logic [7:0]     shreg;
  logic [2:0]     bit_cnt;
  logic           byte_full;
  logic           rw;
  logic           master_ack;
  logic [7:0]     sub;
  logic           wr_en;
  logic [7:0]     wr_addr;
  logic [7:0]     wr_data;
  logic [7:0]     rd_data;
  logic           scl_rise, scl_fall;
  logic           sda_rise, sda_fall;
  logic           start_cond, stop_cond;
  logic           soft_rst, state_wr, state_wr_q;
  logic [7:0]     opcfg;
  logic [7:0]     prot;
  logic [7:0]     gain;
  logic [7:0]     chst;

  // ****************************************************************
  // bus line edges
  // ****************************************************************
  // clock line edges
  amg_edge #(.IDLE_LEVEL(1'b1)) u_scl_edge (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .d       (scl_in),
    .rise    (scl_rise),
    .fall    (scl_fall)
  );

  // data line edges
  amg_edge #(.IDLE_LEVEL(1'b1)) u_sda_edge (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .d       (sda_in),
    .rise    (sda_rise),
    .fall    (sda_fall)
  );

  // start and stop while clock high
  assign start_cond = sda_fall & scl_in;
  assign stop_cond  = sda_rise & scl_in;

  // ****************************************************************
  // serial protocol engine
  // ****************************************************************
  // byte framing, acknowledge and subaddress handling
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sda_out    <= 1'b0;
      state      <= AMG_ST_IDLE;
      shreg      <= 8'h00;
      bit_cnt    <= AMG_BIT_FIRST;
      byte_full  <= 1'b0;
      rw         <= 1'b0;
      master_ack <= 1'b0;
      sub        <= 8'h00;
      sda_oe     <= 1'b0;
      wr_en      <= 1'b0;
      wr_addr    <= 8'h00;
      wr_data    <= 8'h00;
    end else begin
      sda_out <= 1'b0; // data line is only ever pulled low
      wr_en   <= 1'b0;
      if (start_cond) begin
        state     <= AMG_ST_ADDR;
        bit_cnt   <= AMG_BIT_FIRST;
        byte_full <= 1'b0;
        sda_oe    <= 1'b0;
      end else if (stop_cond) begin
        state     <= AMG_ST_IDLE;
        byte_full <= 1'b0;
        sda_oe    <= 1'b0;
      end else if (scl_rise) begin
        case (state)
          AMG_ST_ADDR, AMG_ST_SUB, AMG_ST_WDATA: begin
            shreg   <= {shreg[6:0], sda_in};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == AMG_BIT_LAST) begin
              byte_full <= 1'b1;
            end
          end
          AMG_ST_RDATA: begin
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == AMG_BIT_LAST) begin
              byte_full <= 1'b1;
            end
          end
          AMG_ST_RACK: begin
            master_ack <= ~sda_in;
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state)
          AMG_ST_ADDR: begin
            if (byte_full) begin
              byte_full <= 1'b0;
              if (shreg[7:1] == AMG_DEV_ADDR) begin
                rw     <= shreg[0];
                sda_oe <= 1'b1;
                state  <= AMG_ST_ACK_ADDR;
              end else begin
                state <= AMG_ST_IDLE;
              end
            end
          end
          AMG_ST_ACK_ADDR: begin
            bit_cnt <= AMG_BIT_FIRST;
            if (rw) begin
              shreg  <= {rd_data[6:0], 1'b0};
              sda_oe <= ~rd_data[7];
              sub    <= sub + 8'h01;
              state  <= AMG_ST_RDATA;
            end else begin
              sda_oe <= 1'b0;
              state  <= AMG_ST_SUB;
            end
          end
          AMG_ST_SUB: begin
            if (byte_full) begin
              byte_full <= 1'b0;
              sub       <= shreg;
              sda_oe    <= 1'b1;
              state     <= AMG_ST_ACK_SUB;
            end
          end
          AMG_ST_ACK_SUB, AMG_ST_ACK_WR: begin
            sda_oe  <= 1'b0;
            bit_cnt <= AMG_BIT_FIRST;
            state   <= AMG_ST_WDATA;
          end
          AMG_ST_WDATA: begin
            if (byte_full) begin
              byte_full <= 1'b0;
              wr_en     <= 1'b1;
              wr_addr   <= sub;
              wr_data   <= shreg;
              sub       <= sub + 8'h01;
              sda_oe    <= 1'b1;
              state     <= AMG_ST_ACK_WR;
            end
          end
          AMG_ST_RDATA: begin
            if (byte_full) begin
              byte_full <= 1'b0;
              sda_oe    <= 1'b0;
              state     <= AMG_ST_RACK;
            end else begin
              sda_oe <= ~shreg[7];
              shreg  <= {shreg[6:0], 1'b0};
            end
          end
          AMG_ST_RACK: begin
            bit_cnt <= AMG_BIT_FIRST;
            if (master_ack) begin
              shreg  <= {rd_data[6:0], 1'b0};
              sda_oe <= ~rd_data[7];
              sub    <= sub + 8'h01;
              state  <= AMG_ST_RDATA;
            end else begin
              state <= AMG_ST_IDLE;
            end
          end
          default: begin
            state <= AMG_ST_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // register file
  // ****************************************************************
  // read mux, unlisted offsets read zero
  always_comb begin
    case (sub)
      AMG_OFS_OPCFG: rd_data = {1'b0, opcfg[6:0]};
      AMG_OFS_PROT:  rd_data = prot;
      AMG_OFS_GAIN:  rd_data = gain;
      AMG_OFS_STATE: rd_data = chst;
      default:       rd_data = AMG_RD_NONE;
    endcase
  end

  // self-clearing soft reset request
  assign soft_rst = wr_en && (wr_addr == AMG_OFS_OPCFG) &&
                    wr_data[AMG_BIT_SOFT_RESET];
  assign state_wr = wr_en && (wr_addr == AMG_OFS_STATE) && !soft_rst;

  // register writes, soft reset wins over the rest of its byte
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      opcfg <= AMG_RST_OPCFG;
      prot  <= AMG_RST_PROT;
      gain  <= AMG_RST_GAIN;
      chst  <= AMG_RST_STATE;
    end else if (soft_rst) begin
      opcfg <= AMG_RST_OPCFG;
      prot  <= AMG_RST_PROT;
      gain  <= AMG_RST_GAIN;
      chst  <= AMG_RST_STATE;
    end else if (wr_en) begin
      case (wr_addr)
        AMG_OFS_OPCFG: opcfg <= {1'b0, wr_data[6:0]};
        AMG_OFS_PROT:  prot  <= wr_data;
        AMG_OFS_GAIN:  gain  <= wr_data;
        AMG_OFS_STATE: chst  <= wr_data;
        default: begin
        end
      endcase
    end
  end

  // soft reset strobe and write marker aligned with new value
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      soft_reset_pulse <= 1'b0;
      state_wr_q       <= 1'b0;
    end else begin
      soft_reset_pulse <= soft_rst;
      state_wr_q       <= state_wr;
    end
  end

  // ****************************************************************
  // configuration outputs
  // ****************************************************************

  // operating and protection fields
  assign modulation_select             = opcfg[AMG_BIT_MODULATION];
  assign parallel_bridge_upper_pair    = opcfg[AMG_BIT_UPPER_PAIR];
  assign parallel_bridge_lower_pair    = opcfg[AMG_BIT_LOWER_PAIR];
  assign first_channel_lineout_select  = opcfg[AMG_BIT_LINEOUT_1];
  assign second_channel_lineout_select = opcfg[AMG_BIT_LINEOUT_2];
  assign third_channel_lineout_select  = opcfg[AMG_BIT_LINEOUT_3];
  assign fourth_channel_lineout_select = opcfg[AMG_BIT_LINEOUT_4];
  assign pulse_injection_enable    = prot[AMG_BIT_PULSE_INJ];
  assign thermal_warning_threshold = prot[AMG_LSB_THERMAL +: 2];
  assign overcurrent_level_select  = prot[AMG_LSB_OVERCUR +: 2];

  // per-channel gain and state fields
  assign first_channel_gain_code      = gain[AMG_LSB_CH1 +: 2];
  assign second_channel_gain_code     = gain[AMG_LSB_CH2 +: 2];
  assign third_channel_gain_code      = gain[AMG_LSB_CH3 +: 2];
  assign fourth_channel_gain_code     = gain[AMG_LSB_CH4 +: 2];
  assign first_channel_state_request  = chst[AMG_LSB_CH1 +: 2];
  assign second_channel_state_request = chst[AMG_LSB_CH2 +: 2];
  assign third_channel_state_request  = chst[AMG_LSB_CH3 +: 2];
  assign fourth_channel_state_request = chst[AMG_LSB_CH4 +: 2];

  // ****************************************************************
  // load check triggers, index 0 is channel 1
  // ****************************************************************
  for (genvar i = 0; i < AMG_CHANNELS; i++) begin : g_chan
    amg_chan u_chan (
      .ref_clk              (ref_clk),
      .resetn               (resetn),
      .req_code             (chst[2*(AMG_CHANNELS-1-i) +: 2]),
      .req_written          (state_wr_q),
      .auto_load_check_skip (auto_load_check_skip),
      .channel_fault        (channel_fault[i]),
      .load_check_start     (load_check_start[i])
    );
  end

endmodule

// ---- amg_properties.sv ----
`timescale 1ns/1ps
module amg_properties (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       resetn,
  // serial bus
  input wire logic       scl_in,
  input wire logic       sda_oe,
  // configuration outputs
  input wire logic       modulation_select,
  input wire logic       parallel_bridge_lower_pair,
  input wire logic       pulse_injection_enable,
  input wire logic [1:0] thermal_warning_threshold,
  input wire logic [1:0] overcurrent_level_select,
  input wire logic [1:0] first_channel_gain_code,
  input wire logic [1:0] fourth_channel_gain_code,
  input wire logic [1:0] first_channel_state_request,
  input wire logic [1:0] fourth_channel_state_request,
  input wire logic       soft_reset_pulse,
  // load check
  input wire logic       auto_load_check_skip,
  input wire logic [3:0] channel_fault,
  input wire logic [3:0] load_check_start
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // grouped register fields
  wire logic [4:0] prot_f = {pulse_injection_enable,
                             thermal_warning_threshold,
                             overcurrent_level_select};
  wire logic [3:0] gain_f = {first_channel_gain_code,
                             fourth_channel_gain_code};
  wire logic [3:0] st_f   = {first_channel_state_request,
                             fourth_channel_state_request};

  // ****************************************************************
  // reset values
  // ****************************************************************
  a_opcfg_reset: assert property (
    $rose(resetn) |-> !modulation_select && !parallel_bridge_lower_pair)
    else $error("operating configuration not cleared by reset");
  a_prot_reset: assert property (
    $rose(resetn) |-> prot_f == 5'h04)
    else $error("protection configuration wrong after reset");
  a_gain_reset: assert property (
    $rose(resetn) |-> gain_f == 4'hf)
    else $error("gain codes wrong after reset");
  a_state_reset: assert property (
    $rose(resetn) |-> st_f == 4'h5)
    else $error("state requests wrong after reset");

  // ****************************************************************
  // soft reset
  // ****************************************************************
  a_soft_restore: assert property (
    soft_reset_pulse |-> {modulation_select, prot_f, gain_f, st_f} == 14'h04f5)
    else $error("soft reset left a register changed");
  a_soft_clear: assert property (
    soft_reset_pulse |=> !soft_reset_pulse)
    else $error("soft reset did not clear itself");
  a_soft_no_check: assert property (
    soft_reset_pulse |-> (load_check_start == 4'h0) [*3])
    else $error("load check started by soft reset");

  // ****************************************************************
  // load checks and data line stability
  // ****************************************************************
  a_req_check: assert property (
    $changed(fourth_channel_state_request)
    && fourth_channel_state_request == 2'b11 |-> ##[0:2] load_check_start[3])
    else $error("requested load check missing");
  a_fault_check: assert property (
    $rose(channel_fault[0]) && !auto_load_check_skip
    |-> ##[1:2] load_check_start[0])
    else $error("fault load check missing");
  a_skip_quiet: assert property (
    $rose(channel_fault[1]) && auto_load_check_skip
    |=> (!load_check_start[1]) [*2])
    else $error("load check ran while skipped");
  a_hiz_leave: assert property (
    $past(first_channel_state_request) == 2'b01
    && first_channel_state_request == 2'b00 && !auto_load_check_skip
    |-> ##[0:2] load_check_start[0])
    else $error("load check missing on leaving hi-z");
  a_sda_quiet: assert property (
    scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("data changed while serial clock high");

  // main scenarios
  c_soft: cover property (soft_reset_pulse);
  c_check: cover property (load_check_start[0]);
  c_ack: cover property ($rose(sda_oe));
endmodule

// ---- amg_host.sv ----
`timescale 1ns/1ps
module amg_host (
  // clock
  input  wire logic ref_clk,
  // serial bus
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_pull
);
  // bus idles released, clock high
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // one bus phase of four reference cycles
  task automatic tick();
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  // start or repeated start: data falls while clock high
  task automatic start();
    sda_pull = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    sda_pull = 1'b1;
    tick();
    scl = 1'b0;
    tick();
  endtask

  // stop: data rises while clock high
  task automatic stop();
    sda_pull = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    sda_pull = 1'b0;
    tick();
  endtask

  // one bit, data set while clock low, sampled late in high
  task automatic bit_io(input logic b, output logic s);
    sda_pull = ~b;
    tick();
    scl = 1'b1;
    tick();
    s = sda_in;
    scl = 1'b0;
    tick();
  endtask

  // eight bits msb first plus acknowledge slot
  task automatic byte_io(input logic [7:0] d, input logic ack_in,
                         output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ack_in, ack);
  endtask
endmodule

// ---- amg_mode_gain_state_regs_tb.sv ----
`timescale 1ns/1ps
module amg_mode_gain_state_regs_tb;
  import amg_pkg::*;

  // ****************************************************************
  // signals
  // ****************************************************************
  localparam logic [31:0] RST = {AMG_RST_OPCFG, AMG_RST_PROT,
                                 AMG_RST_GAIN, AMG_RST_STATE};
  localparam logic [31:0] M   = 32'h7f7cffff;
  logic             ref_clk;
  logic             resetn;
  logic             skip;
  logic [3:0]       fault;
  logic [31:0]      r;
  logic [31:0]      exp_v;
  logic [7:0]       q;
  logic             a;
  wire logic        scl, pull, sda_out, sda_oe, sda, srp;
  wire logic        mod, pu, pl, l1, l2, l3, l4, pie;
  wire logic [1:0]  tw, oc, g1, g2, g3, g4, s1, s2, s3, s4;
  wire logic [3:0]  lcs;
  int               err_count;
  int               num_checks;
  int               srp_n;
  int               lc[4];
  int               base[4];
  logic [15:0]      rows [11] = '{
    16'h0140, 16'h0115, 16'h012a,
    16'h02c3, 16'h0254, 16'h0228, 16'h023c,
    16'h031b, 16'h03e4, 16'h0418, 16'h0492};
  wire logic [31:0] view = {1'b0, mod, pu, pl, l1, l2, l3, l4, 1'b0, pie,
                            tw, oc, 2'b00, g1, g2, g3, g4, s1, s2, s3, s4};

  // open-drain data line with pull-up
  assign sda = (sda_oe ? sda_out : 1'b1) & ~pull;

  amg_mode_gain_state_regs uut (
    .ref_clk(ref_clk), .resetn(resetn), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .modulation_select(mod),
    .parallel_bridge_upper_pair(pu), .parallel_bridge_lower_pair(pl),
    .first_channel_lineout_select(l1), .second_channel_lineout_select(l2),
    .third_channel_lineout_select(l3), .fourth_channel_lineout_select(l4),
    .soft_reset_pulse(srp), .pulse_injection_enable(pie),
    .thermal_warning_threshold(tw), .overcurrent_level_select(oc),
    .first_channel_gain_code(g1), .second_channel_gain_code(g2),
    .third_channel_gain_code(g3), .fourth_channel_gain_code(g4),
    .first_channel_state_request(s1), .second_channel_state_request(s2),
    .third_channel_state_request(s3), .fourth_channel_state_request(s4),
    .auto_load_check_skip(skip), .channel_fault(fault),
    .load_check_start(lcs));

  amg_host host (.ref_clk(ref_clk), .sda_in(sda), .scl(scl),
                 .sda_pull(pull));

  // clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // pulse counters
  always @(posedge ref_clk) begin
    for (int i = 0; i < 4; i++) if (lcs[i] === 1'b1) lc[i]++;
    if (srp === 1'b1) srp_n++;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic cmp(input logic [31:0] got, input logic [31:0] want);
    num_checks++;
    if (got !== want) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic sb(input logic [7:0] d);
    logic [7:0] x;
    logic       k;
    host.byte_io(d, 1'b1, x, k);
    cmp({31'h0, k}, 32'h0);
  endtask

  task automatic wr(input logic [7:0] sub, input logic [31:0] d, input int n);
    host.start();
    sb({AMG_DEV_ADDR, 1'b0});
    sb(sub);
    for (int i = 0; i < n; i++) sb(d[31-8*i -: 8]);
    host.stop();
  endtask

  task automatic rd(input logic [7:0] sub, input int n);
    logic [7:0] x;
    logic       k;
    r = 32'h0;
    host.start();
    sb({AMG_DEV_ADDR, 1'b0});
    sb(sub);
    host.start();
    sb({AMG_DEV_ADDR, 1'b1});
    for (int i = 0; i < n; i++) begin
      host.byte_io(8'hff, i == n - 1, x, k);
      r[31-8*i -: 8] = x;
    end
    host.stop();
  endtask

  task automatic chk_all();
    rd(8'h01, 4);
    cmp(r, exp_v);
    cmp(view & M, exp_v & M);
  endtask

  task automatic lc_step(input logic [3:0] d);
    for (int i = 0; i < 4; i++) begin
      cmp(lc[i] - base[i], {31'h0, d[i]});
      base[i] = lc[i];
    end
  endtask

  task automatic conclude();
    if (err_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    resetn = 1'b0;
    skip = 1'b0;
    fault = 4'h0;
    idle(10);
    resetn = 1'b1;
    idle(2);
    exp_v = RST;
    chk_all();
    for (int i = 0; i < 11; i++) begin
      wr(rows[i][15:8], {rows[i][7:0], 24'h0}, 1);
      exp_v[8*(4-rows[i][15:8]) +: 8] = rows[i][7:0];
      chk_all();
    end
    resetn = 1'b0;
    idle(2);
    resetn = 1'b1;
    idle(2);
    cmp(view & M, RST & M);
    exp_v = 32'h3f7c1b92;
    wr(8'h01, exp_v, 4);
    chk_all();
    srp_n = 0;
    wr(8'h01, 32'hc0000000, 1);
    exp_v = RST;
    chk_all();
    cmp(srp_n, 32'h1);
    rd(8'h05, 1);
    cmp(r, 32'h0);
    host.start();
    host.byte_io({AMG_DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, q, a);
    host.stop();
    cmp({31'h0, a}, 32'h1);
    base = lc;
    skip = 1'b1;
    wr(8'h04, 32'hff000000, 1);
    lc_step(4'hf);
    wr(8'h04, 32'hff000000, 1);
    lc_step(4'hf);
    wr(8'h04, 32'h55000000, 1);
    wr(8'h04, 32'h00000000, 1);
    lc_step(4'h0);
    skip = 1'b0;
    wr(8'h04, 32'h55000000, 1);
    wr(8'h04, 32'h00000000, 1);
    lc_step(4'hf);
    fault = 4'h5;
    idle(4);
    lc_step(4'h5);
    fault = 4'h0;
    skip = 1'b1;
    idle(2);
    fault = 4'ha;
    idle(4);
    lc_step(4'h0);
    conclude();
  end

  // hang guard
  initial begin
    repeat (90000) @(posedge ref_clk);
    err_count++;
    conclude();
  end
endmodule

bind amg_mode_gain_state_regs amg_properties chk (
  .ref_clk(ref_clk), .resetn(resetn), .scl_in(scl_in), .sda_oe(sda_oe),
  .modulation_select(modulation_select),
  .parallel_bridge_lower_pair(parallel_bridge_lower_pair),
  .pulse_injection_enable(pulse_injection_enable),
  .thermal_warning_threshold(thermal_warning_threshold),
  .overcurrent_level_select(overcurrent_level_select),
  .first_channel_gain_code(first_channel_gain_code),
  .fourth_channel_gain_code(fourth_channel_gain_code),
  .first_channel_state_request(first_channel_state_request),
  .fourth_channel_state_request(fourth_channel_state_request),
  .soft_reset_pulse(soft_reset_pulse),
  .auto_load_check_skip(auto_load_check_skip),
  .channel_fault(channel_fault), .load_check_start(load_check_start));
